// >>> src/asm_defs.svh
// Notes on behaviour
// - Slot codes 0..31: TDM slot equals code; I2S/LJ left slot of that index.
// - Slot codes 32..63: TDM slot equals code; I2S/LJ right slot code minus 32.
// - Line bit 0 routes channel to primary output, 1 to general pin; resets 0.
// - Channel 7 register resets to 0x06: slot 6, primary output.
// - Channel 8 register resets to 0x07: slot 7, primary output.
// - Role bit 0 makes device target with clocks input; 1 makes it controller.
// - Auto clock bit 0 derives dividers and PLL internally; 1 uses custom settings.
// - In auto clocking, PLL-off bit 0 keeps PLL on, 1 disables it.
// - Gate bit forces outgoing bit clock and frame sync off, controller mode only.
// - Rate family bit picks 48 kHz family at 0, 44.1 kHz family at 1, controller mode only.
// - Master clock code 0..7 declares PLL source frequency in controller mode when code mode is 0.
// - Controller configuration register resets to 0x02.
`ifndef ASM_DEFS_SVH
`define ASM_DEFS_SVH

`define ASM_ADDR_CH7 8'h11
`define ASM_ADDR_CH8 8'h12
`define ASM_ADDR_CFG0 8'h13

`define ASM_RST_CH7 8'h06
`define ASM_RST_CH8 8'h07
`define ASM_RST_CFG0 8'h02

`define ASM_SLOT_MASK 8'h7f
`define ASM_LINE_BIT 6
`define ASM_HALF_BIT 5
`define ASM_ROLE_BIT 7
`define ASM_AUTO_BIT 6
`define ASM_PLL_OFF_BIT 5
`define ASM_GATE_BIT 4
`define ASM_FAMILY_BIT 3
`define ASM_MCLK_HI 2

`define ASM_MCLK_KHZ_0 16'h2ee0
`define ASM_MCLK_KHZ_1 16'h3000
`define ASM_MCLK_KHZ_2 16'h32c8
`define ASM_MCLK_KHZ_3 16'h3e80
`define ASM_MCLK_KHZ_4 16'h4b00
`define ASM_MCLK_KHZ_5 16'h4ce0
`define ASM_MCLK_KHZ_6 16'h5dc0
`define ASM_MCLK_KHZ_7 16'h6000

`endif

// >>> src/asm_pkg.sv
package asm_pkg;
	typedef enum logic {
		asm_role_target,
		asm_role_controller
	} asm_role_type;

	typedef enum logic {
		asm_family_48k,
		asm_family_44k1
	} asm_family_type;
endpackage

// >>> src/asm_slot_clock_cfg.sv
`timescale 1ns/100ps
`include "asm_defs.svh"

// Channel 7/8 slot map and controller clock configuration register 0.
module asm_slot_clock_cfg (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic master_clock_code_mode,
	output logic [5:0] chan7_tdm_slot,
	output logic chan7_right_half,
	output logic [4:0] chan7_half_slot,
	output logic chan7_line_select,
	output logic [5:0] chan8_tdm_slot,
	output logic chan8_right_half,
	output logic [4:0] chan8_half_slot,
	output logic chan8_line_select,
	output asm_pkg::asm_role_type port_role_select,
	output logic clocks_are_outputs,
	output logic auto_clock_on,
	output logic pll_enable,
	output logic serial_clock_gate,
	output asm_pkg::asm_family_type rate_family_select,
	output logic [2:0] master_clock_freq_code,
	output logic master_clock_valid,
	output logic [15:0] master_clock_khz
);
	logic [7:0] ch7_reg;
	logic [7:0] ch8_reg;
	logic [7:0] cfg0_reg;
	logic is_ctrl;
	logic custom_clock;
	logic [2:0] code_field;

	// One compare serves both the write and the read decode, so they cannot drift apart.
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
		addr_hit = (addr == target);
	endfunction

	// Declared source frequency in kHz for each three-bit master clock code.
	function automatic logic [15:0] mclk_khz(input logic [2:0] code);
		case (code)
			3'h0: mclk_khz = `ASM_MCLK_KHZ_0;
			3'h1: mclk_khz = `ASM_MCLK_KHZ_1;
			3'h2: mclk_khz = `ASM_MCLK_KHZ_2;
			3'h3: mclk_khz = `ASM_MCLK_KHZ_3;
			3'h4: mclk_khz = `ASM_MCLK_KHZ_4;
			3'h5: mclk_khz = `ASM_MCLK_KHZ_5;
			3'h6: mclk_khz = `ASM_MCLK_KHZ_6;
			default: mclk_khz = `ASM_MCLK_KHZ_7;
		endcase
	endfunction

	// Channel 7 slot register; the reserved top bit is dropped on the way in.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ch7_reg <= `ASM_RST_CH7;
		end else if (ce && reg_write && addr_hit(reg_addr, `ASM_ADDR_CH7)) begin
			ch7_reg <= reg_wdata & `ASM_SLOT_MASK;
		end
	end

	// Channel 8 slot register; the reserved top bit is dropped on the way in.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ch8_reg <= `ASM_RST_CH8;
		end else if (ce && reg_write && addr_hit(reg_addr, `ASM_ADDR_CH8)) begin
			ch8_reg <= reg_wdata & `ASM_SLOT_MASK;
		end
	end

	// Controller configuration register 0 keeps all eight bits.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cfg0_reg <= `ASM_RST_CFG0;
		end else if (ce && reg_write && addr_hit(reg_addr, `ASM_ADDR_CFG0)) begin
			cfg0_reg <= reg_wdata;
		end
	end

	// A read strobe is answered one cycle later; the valid pulse lasts one cycle.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			reg_rvalid <= 1'b0;
		end else if (ce) begin
			reg_rvalid <= reg_read;
		end
	end

	// Unmapped addresses read as zero; read data holds until the next read.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (ce && reg_read) begin
			if (addr_hit(reg_addr, `ASM_ADDR_CH7)) begin
				reg_rdata <= ch7_reg;
			end else if (addr_hit(reg_addr, `ASM_ADDR_CH8)) begin
				reg_rdata <= ch8_reg;
			end else if (addr_hit(reg_addr, `ASM_ADDR_CFG0)) begin
				reg_rdata <= cfg0_reg;
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	// Each channel has its own decoder so the two maps stay independent.
	asm_slot_decode u_ch7 (
		.clk_sys(clk_sys),
		.reset(reset),
		.ce(ce),
		.slot_reg(ch7_reg),
		.tdm_slot(chan7_tdm_slot),
		.right_half(chan7_right_half),
		.half_slot(chan7_half_slot),
		.line_select(chan7_line_select)
	);

	asm_slot_decode u_ch8 (
		.clk_sys(clk_sys),
		.reset(reset),
		.ce(ce),
		.slot_reg(ch8_reg),
		.tdm_slot(chan8_tdm_slot),
		.right_half(chan8_right_half),
		.half_slot(chan8_half_slot),
		.line_select(chan8_line_select)
	);

	assign is_ctrl = cfg0_reg[`ASM_ROLE_BIT];
	assign custom_clock = cfg0_reg[`ASM_AUTO_BIT];
	assign code_field = cfg0_reg[`ASM_MCLK_HI:0];

	// Role as an enumerated value for the serial port.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			port_role_select <= asm_pkg::asm_role_target;
		end else if (ce) begin
			port_role_select <= is_ctrl ? asm_pkg::asm_role_controller : asm_pkg::asm_role_target;
		end
	end

	// High when bit clock and frame sync are driven by this device.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			clocks_are_outputs <= 1'b0;
		end else if (ce) begin
			clocks_are_outputs <= is_ctrl;
		end
	end

	// The register bit is an active-low enable, so it is inverted here.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			auto_clock_on <= 1'b1;
		end else if (ce) begin
			auto_clock_on <= ~custom_clock;
		end
	end

	// In custom mode the PLL state is owned by software settings, so stay on here.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pll_enable <= 1'b1;
		end else if (ce) begin
			pll_enable <= custom_clock | ~cfg0_reg[`ASM_PLL_OFF_BIT];
		end
	end

	// Gating only matters for clocks that this device drives out.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			serial_clock_gate <= 1'b0;
		end else if (ce) begin
			serial_clock_gate <= is_ctrl & cfg0_reg[`ASM_GATE_BIT];
		end
	end

	// In target mode the family bit is ignored and the default family is shown.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rate_family_select <= asm_pkg::asm_family_48k;
		end else if (ce) begin
			rate_family_select <= (is_ctrl && cfg0_reg[`ASM_FAMILY_BIT])
				? asm_pkg::asm_family_44k1 : asm_pkg::asm_family_48k;
		end
	end

	// Raw master clock code, passed on as written.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			master_clock_freq_code <= 3'h2;
		end else if (ce) begin
			master_clock_freq_code <= code_field;
		end
	end

	// The code is meaningful only for a controller reading it as a frequency.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			master_clock_valid <= 1'b0;
		end else if (ce) begin
			master_clock_valid <= is_ctrl & ~master_clock_code_mode;
		end
	end

	// Frequency is always decoded; the valid flag says whether it applies.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			master_clock_khz <= `ASM_MCLK_KHZ_2;
		end else if (ce) begin
			master_clock_khz <= mclk_khz(code_field);
		end
	end
endmodule

// >>> src/asm_slot_decode.sv
`timescale 1ns/100ps
`include "asm_defs.svh"

// Turns one slot register into the placement seen by the serial port.
module asm_slot_decode (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	input wire logic [7:0] slot_reg,
	output logic [5:0] tdm_slot,
	output logic right_half,
	output logic [4:0] half_slot,
	output logic line_select
);
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tdm_slot <= 6'h00;
			right_half <= 1'b0;
			half_slot <= 5'h00;
			line_select <= 1'b0;
		end else if (ce) begin
			tdm_slot <= slot_reg[5:0];
			right_half <= slot_reg[`ASM_HALF_BIT];
			half_slot <= slot_reg[4:0];
			line_select <= slot_reg[`ASM_LINE_BIT];
		end
	end
endmodule

// >>> verif/asm_cfg_assertions.sv
`timescale 1ns/100ps
module asm_cfg_checker (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic reg_rvalid,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [5:0] chan7_tdm_slot,
	input wire logic chan7_right_half,
	input wire logic chan8_line_select,
	input wire logic clocks_are_outputs,
	input wire logic serial_clock_gate
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	a_read_ack: assert property (ce && reg_read |=> reg_rvalid) else $error("no ack");
	a_ack_cause: assert property (reg_rvalid && $past(ce) |-> $past(reg_read)) else $error("ack");
	a_slot_write: assert property (ce && reg_write && reg_addr == 8'h11 |=>
		##1 chan7_tdm_slot == $past(reg_wdata[5:0], 2)) else $error("slot");
	a_half_split: assert property (ce && reg_write && reg_addr == 8'h11 |=>
		##1 chan7_right_half == $past(reg_wdata[5], 2)) else $error("half");
	a_line_write: assert property (ce && reg_write && reg_addr == 8'h12 |=>
		##1 chan8_line_select == $past(reg_wdata[6], 2)) else $error("line");
	a_role_write: assert property (ce && reg_write && reg_addr == 8'h13 |=>
		##1 clocks_are_outputs == $past(reg_wdata[7], 2)) else $error("role");
	a_gate_write: assert property (ce && reg_write && reg_addr == 8'h13 |=>
		##1 serial_clock_gate == ($past(reg_wdata[7], 2) && $past(reg_wdata[4], 2))) else $error("gate");
	a_gate_target: assert property (!clocks_are_outputs |-> !serial_clock_gate) else $error("gated");
endmodule
bind asm_slot_clock_cfg asm_cfg_checker chk (.*);

// >>> verif/asm_clk_src_model.sv
`timescale 1ns/100ps
// Stands in for the clock source register that says how the code is read.
module asm_clk_src_model (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic mode_set,
	output logic master_clock_code_mode
);
	always_ff @(posedge clk_sys) begin
		master_clock_code_mode <= reset ? 1'h0 : mode_set;
	end
endmodule

// >>> verif/asm_slot_clock_cfg_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; $display("Error %0t mismatch %h %h", $time, a, b); end end
module asm_slot_clock_cfg_tb;
	logic clk_sys = 1'h0, reset = 1'h1, ce = 1'h1, reg_write = 1'h0, reg_read = 1'h0;
	logic mode_set = 1'h0, reg_rvalid, chan7_right_half, chan7_line_select, chan8_right_half;
	logic chan8_line_select, clocks_are_outputs, auto_clock_on, pll_enable, serial_clock_gate;
	logic master_clock_valid, master_clock_code_mode;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [5:0] chan7_tdm_slot, chan8_tdm_slot;
	logic [4:0] chan7_half_slot, chan8_half_slot;
	logic [2:0] master_clock_freq_code;
	logic [15:0] master_clock_khz;
	asm_pkg::asm_role_type port_role_select;
	asm_pkg::asm_family_type rate_family_select;
	int mismatches = 0, comparisons = 0;
	wire [7:0] cfg_out = {2'h0, clocks_are_outputs, auto_clock_on, pll_enable, serial_clock_gate,
		rate_family_select, master_clock_valid};
	logic [15:0] khz_exp[8] = '{16'h2ee0, 16'h3000, 16'h32c8, 16'h3e80, 16'h4b00, 16'h4ce0,
		16'h5dc0, 16'h6000};
	logic [39:0] rows[8] = '{40'h05aa120718, 40'h0500130218, 40'h11a0112018, 40'h12ff127f18,
		40'h139805003f, 40'h1318131818, 40'h1320132010, 40'h1360136008};
	asm_slot_clock_cfg dut (.*);
	asm_clk_src_model host (.*);
	initial forever #5 clk_sys = ~clk_sys;
	task automatic xfer(input logic [39:0] r);
		@(posedge clk_sys) #1;
		{reg_addr, reg_wdata} = r[39:24];
		reg_write = 1'h1;
		@(posedge clk_sys) #1;
		reg_write = 1'h0;
		reg_addr = r[23:16];
		reg_read = 1'h1;
		@(posedge clk_sys) #1;
		reg_read = 1'h0;
		`CHK(reg_rvalid, 1'h1)
		`CHK(reg_rdata, r[15:8])
		`CHK(cfg_out, r[7:0])
	endtask
	task automatic tally_and_finish;
		$display("%0d checks, %0d errors", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#3000;
		mismatches++;
		tally_and_finish;
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		#1 reset = 1'h0;
		foreach (rows[i]) xfer(rows[i]);
		`CHK({chan7_tdm_slot, chan7_right_half, chan7_half_slot, chan8_line_select}, 13'h1041)
		`CHK({chan8_tdm_slot, chan8_right_half, chan8_half_slot, chan7_line_select}, 13'h1ffe)
		for (int i = 0; i < 8; i++) begin
			xfer(40'h1380138039 + {8'h00, i[7:0], 8'h00, i[7:0], 8'h00});
			`CHK(master_clock_khz, khz_exp[i])
			`CHK(master_clock_freq_code, i[2:0])
		end
		`CHK(master_clock_khz, 16'h6000)
		`CHK(port_role_select, asm_pkg::asm_role_controller)
		mode_set = 1'h1;
		xfer(40'h1380138038);
		reset = 1'h1;
		@(posedge clk_sys) #1;
		reset = 1'h0;
		xfer(40'h05aa110618);
		`CHK(master_clock_khz, 16'h32c8)
		`CHK({chan7_tdm_slot, chan8_tdm_slot, chan7_line_select}, 13'h030e)
		tally_and_finish;
	end
endmodule
